// *** logic/svt_pkg.sv ***
/*
 * svt_pkg: constants for the supply trip detector control logic.
 * assumes an AHB-Lite slave with 32-bit data and word-aligned registers.
 */
package svt_pkg;
   // =====================================================================
   // register map
   localparam logic [7:0] CTRL_OFFSET   = 8'h00;  // voltage_detect_control
   localparam logic [7:0] STATUS_OFFSET = 8'h04;  // event flag and irq enable
   // =====================================================================
   // control field positions
   localparam int LEVEL_LSB   = 0;
   localparam int LEVEL_MSB   = 3;
   localparam int ENABLE_BIT  = 4;
   localparam int STABLE_BIT  = 5;
   localparam int DIR_BIT     = 7;
   // status field positions
   localparam int FLAG_BIT    = 0;
   localparam int IRQEN_BIT   = 1;
   // =====================================================================
   // level codes: reset value and external input
   localparam logic [3:0] LEVEL_RESET = 4'h5;
   localparam logic [3:0] LEVEL_EXT   = 4'hf;
   // settle time of the reference after each enabling, in ns
   localparam int SETTLE_NS         = 20000;
   localparam int CLK_PERIOD_NS     = 100;
   localparam int SETTLE_CYCLES     = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // stabilisation state
   typedef enum logic [1:0] {
      SVT_OFF    = 2'b00,
      SVT_SETTLE = 2'b01,
      SVT_STABLE = 2'b11
   } svt_state_e;
endpackage

// *** logic/svt_detector.sv ***
/*
 * svt_detector: digital control and flag logic of a supply trip detector.
 * assumes analog comparator, tap mux and reference live outside; their
 * results arrive asynchronously and are synchronised here.
 */
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module svt_detector #(
   parameter int SETTLE_COUNT = svt_pkg::SETTLE_CYCLES
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // analog front end
   input  wire logic        cmpAbove,
   input  wire logic        refSettled,
   output logic             detectorOn,
   output logic [3:0]       tripLevelSelect,
   output logic             externalTripInput,
   // system
   output logic             wakeRequest,
   output logic             irqRequest
);
   import svt_pkg::*;

   // parameter sanity
   // the settle counter is 16 bits wide, so longer counts cannot be served
   if (SETTLE_COUNT < 1 || SETTLE_COUNT > 65536) begin : g_chk
      $error("SETTLE_COUNT must lie between 1 and 65536");
   end

   logic       tripDirectionSelect;
   logic       detectorPowerEnable;
   logic [3:0] tripLevel;
   logic       referenceStableFlag;
   logic       voltageEventFlag;
   logic       voltageEventIrqEnable;
   svt_state_e state;
   logic [15:0] settleCnt;
   logic [2:0] cmpSync;
   logic [2:0] refSync;
   logic       cmpLevel;
   logic       refLevel;
   logic       wrPend;
   logic [7:0] wrAddr;
   logic       trip;
   logic       wrCtrl;
   logic       wrStatus;
   logic [7:0] ctrlView;
   logic [1:0] statusView;

   // =====================================================================
   // bus slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // capture the address phase of a write
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         wrPend <= 1'b0;
         wrAddr <= 8'h00;
      end else if (hready) begin
         wrPend <= hsel && htrans[1] && hwrite;
         wrAddr <= haddr[7:0];
      end
   end

   assign wrCtrl   = wrPend && (wrAddr == CTRL_OFFSET);
   assign wrStatus = wrPend && (wrAddr == STATUS_OFFSET);

   // a read right behind a write must see the word being written, not the old one
   assign ctrlView   = wrCtrl ? {hwdata[DIR_BIT], 1'b0, referenceStableFlag,
                                 hwdata[ENABLE_BIT], hwdata[LEVEL_MSB:LEVEL_LSB]}
                              : {tripDirectionSelect, 1'b0, referenceStableFlag,
                                 detectorPowerEnable, tripLevel};
   assign statusView = wrStatus ? {hwdata[IRQEN_BIT], (trip || hwdata[FLAG_BIT])}
                                : {voltageEventIrqEnable, voltageEventFlag};

   // read data registered in the address phase; unmapped reads zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr[7:0] == CTRL_OFFSET) begin
            hrdata <= {24'h000000, ctrlView};
         end else if (haddr[7:0] == STATUS_OFFSET) begin
            hrdata <= {30'h0000_0000, statusView};
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   // =====================================================================
   // control register; stable flag is not writable
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tripDirectionSelect <= 1'b0;
         detectorPowerEnable <= 1'b0;
         tripLevel           <= LEVEL_RESET;
      end else if (wrCtrl) begin
         tripDirectionSelect <= hwdata[DIR_BIT];
         detectorPowerEnable <= hwdata[ENABLE_BIT];
         tripLevel           <= hwdata[LEVEL_MSB:LEVEL_LSB];
      end
   end

   // analog steering follows the register directly
   assign detectorOn        = detectorPowerEnable;
   assign tripLevelSelect   = tripLevel;
   assign externalTripInput = detectorPowerEnable && (tripLevel == LEVEL_EXT);

   // =====================================================================
   // three-stage synchronisers; only stages two and three are looked at
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmpSync  <= 3'h0;
         refSync  <= 3'h0;
         cmpLevel <= 1'b0;
         refLevel <= 1'b0;
      end else begin
         cmpSync <= {cmpSync[1:0], cmpAbove};
         refSync <= {refSync[1:0], refSettled};
         if (cmpSync[1] == cmpSync[2]) begin
            cmpLevel <= cmpSync[2];
         end
         if (refSync[1] == refSync[2]) begin
            refLevel <= refSync[2];
         end
      end
   end

   // =====================================================================
   // settling: a fresh count after every enabling, plus analog settled
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state     <= SVT_OFF;
         settleCnt <= 16'h0000;
      end else begin
         case (state)
            SVT_OFF: begin
               settleCnt <= 16'h0000;
               if (detectorPowerEnable) begin
                  state <= SVT_SETTLE;
               end
            end
            SVT_SETTLE: begin
               if (!detectorPowerEnable) begin
                  state <= SVT_OFF;
               end else if (settleCnt >= 16'(SETTLE_COUNT - 1) && refLevel) begin
                  state <= SVT_STABLE;
               end else if (settleCnt < 16'(SETTLE_COUNT - 1)) begin
                  settleCnt <= settleCnt + 16'h0001;
               end
            end
            SVT_STABLE: begin
               if (!detectorPowerEnable) begin
                  state <= SVT_OFF;
               end
            end
            default: state <= SVT_OFF;
         endcase
      end
   end

   assign referenceStableFlag = (state == SVT_STABLE);

   // =====================================================================
   // trip condition; comparator high means supply at or above set point
   assign trip = referenceStableFlag &&
                 (tripDirectionSelect ? cmpLevel : !cmpLevel);

   // sticky event flag, write 0 to bit 0 clears; a set wins the same cycle
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         voltageEventFlag      <= 1'b0;
         voltageEventIrqEnable <= 1'b0;
      end else begin
         if (trip) begin
            voltageEventFlag <= 1'b1;
         end else if (wrStatus) begin
            voltageEventFlag <= hwdata[FLAG_BIT];
         end
         if (wrStatus) begin
            voltageEventIrqEnable <= hwdata[IRQEN_BIT];
         end
      end
   end

   // sleep wake runs off the flag regardless of the interrupt enable
   assign wakeRequest = voltageEventFlag;
   assign irqRequest  = voltageEventFlag && voltageEventIrqEnable;

   // =====================================================================
   // checks
   a_no_early_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ($rose(voltageEventFlag) && !$past(wrStatus)) |-> $past(referenceStableFlag))
      else $error("event flag set before reference stable");
   a_low_trip_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (referenceStableFlag && !tripDirectionSelect && !cmpLevel) |=> voltageEventFlag)
      else $error("low trip did not set flag");
   a_high_trip_sets: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (referenceStableFlag && tripDirectionSelect && cmpLevel) |=> voltageEventFlag)
      else $error("high trip did not set flag");
   a_enable_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      wrCtrl |=> detectorOn == $past(hwdata[ENABLE_BIT]))
      else $error("enable bit not taken");
   a_stable_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !detectorPowerEnable |=> !referenceStableFlag)
      else $error("stable flag held while disabled");
   a_ext_route: assert property (@(posedge clk_sys) disable iff (!rst_b)
      externalTripInput |-> tripLevelSelect == LEVEL_EXT && detectorOn)
      else $error("external input routed wrongly");
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
      irqRequest == (voltageEventFlag && voltageEventIrqEnable) && wakeRequest == voltageEventFlag)
      else $error("interrupt request mismatch");
   a_settle_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(detectorPowerEnable) |=> !referenceStableFlag [*2])
      else $error("stable too soon after enabling");
   a_sync_delay: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(cmpLevel) |-> $past(cmpSync[2]) == cmpLevel)
      else $error("comparator level not synchronised");
   c_enable_stable: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(referenceStableFlag));
   c_low_event: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(voltageEventFlag) && !tripDirectionSelect);
   c_high_event: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(voltageEventFlag) && tripDirectionSelect);
   c_irq: cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(irqRequest));
endmodule

// *** test/svt_detector_tb.sv ***
/*
 * svt_detector_tb: self-checking bench for the supply trip detector logic.
 * assumes the design answers with zero wait states; comparator inputs are driven here.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
   $display("BAD %s expected %h seen %h", nm, ex, got); end end
module svt_detector_tb;
   import svt_pkg::*;
   localparam int SETTLE = 4;  // short settle count keeps the run brief
   logic clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rdv;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic hreadyout, hresp, cmpAbove = 1'b1, refSettled = 1'b0;
   logic detectorOn, externalTripInput, wakeRequest, irqRequest;
   logic [3:0]  tripLevelSelect;
   int bad_count = 0, n_compared = 0;
   logic [31:0] rowW [3] = '{32'h4a, 32'h8c, 32'h20};
   logic [31:0] rowE [3] = '{32'h0a, 32'h8c, 32'h00};
   // =====================================================================
   // clock, single slave so its ready is the bus ready
   always #50 clk_sys = ~clk_sys;
   assign hready = hreadyout;
   svt_detector #(.SETTLE_COUNT(SETTLE)) u_svt_detector (.clk_sys(clk_sys), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cmpAbove(cmpAbove), .refSettled(refSettled), .detectorOn(detectorOn),
      .tripLevelSelect(tripLevelSelect), .externalTripInput(externalTripInput),
      .wakeRequest(wakeRequest), .irqRequest(irqRequest));
   // =====================================================================
   // verdict in one place
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // bounded wait for ready at a rising edge; a stuck bus ends the run
   task automatic waitReady();
      int k;
      k = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
         k++;
         if (k > 20) begin
            bad_count++;
            $display("BAD hreadyout expected 1 seen %b", hreadyout);
            wrap_up();
         end
         @(posedge clk_sys);
      end
   endtask
   // one single word transfer; read data taken at the data phase edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'h2; hsize <= 3'h2;
      waitReady();
      htrans <= 2'h0; hwdata <= d;
      waitReady();
      rdv = hrdata;
   endtask
   // re-read until the masked value appears; slow settling is allowed for
   task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
      int k;
      k = 0;
      do begin bus(1'b0, a, '0); k++; end while (((rdv & m) !== e) && k < 50);
      `CHK("poll", e, rdv & m)
   endtask
   task automatic pulseReset();
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
   endtask
   // =====================================================================
   // main sequence
   initial begin
      pulseReset();
      `CHK("tripLevelSelect", LEVEL_RESET, tripLevelSelect)
      `CHK("detectorOn", 1'b0, detectorOn)
      `CHK("hresp", 1'b0, hresp)
      bus(1'b0, CTRL_OFFSET, '0); `CHK("ctrl reset", 32'h05, rdv)
      bus(1'b0, STATUS_OFFSET, '0); `CHK("status reset", 32'h0, rdv)
      // table rows: reserved bit 6 and read-only bit 5 must not stick
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, CTRL_OFFSET, rowW[i]);
         bus(1'b0, CTRL_OFFSET, '0); `CHK("ctrl row", rowE[i], rdv)
         `CHK("level out", rowW[i][3:0], tripLevelSelect)
         `CHK("detectorOn row", 1'b0, detectorOn)
      end
      bus(1'b1, 32'h08, 32'hffffffff); bus(1'b0, 32'h08, '0);
      `CHK("unmapped", 32'h0, rdv)
      // trip held present while the reference is unsettled: no flag
      cmpAbove <= 1'b0;
      bus(1'b1, CTRL_OFFSET, 32'h13);
      // the write lands on the edge just passed; look one edge later
      @(posedge clk_sys);
      `CHK("detectorOn on", 1'b1, detectorOn)
      repeat (6) bus(1'b0, STATUS_OFFSET, '0);
      `CHK("flag early", 32'h0, rdv)
      bus(1'b0, CTRL_OFFSET, '0); `CHK("stable early", 32'h13, rdv)
      refSettled <= 1'b1;
      poll(CTRL_OFFSET, 32'h20, 32'h20);
      poll(STATUS_OFFSET, 32'h1, 32'h1);
      `CHK("wake", 1'b1, wakeRequest)
      `CHK("irq masked", 1'b0, irqRequest)
      // remove the trip, then clear the stale flag and enable the request in one write
      cmpAbove <= 1'b1;
      repeat (8) @(posedge clk_sys);
      bus(1'b1, STATUS_OFFSET, 32'h2);
      bus(1'b0, STATUS_OFFSET, '0); `CHK("cleared", 32'h2, rdv)
      `CHK("irq idle", 1'b0, irqRequest)
      // reconfigure in the software order: off, level, direction, on, clear
      bus(1'b1, CTRL_OFFSET, 32'h03);
      bus(1'b1, CTRL_OFFSET, 32'h83);
      bus(1'b1, CTRL_OFFSET, 32'h93);
      bus(1'b1, STATUS_OFFSET, 32'h2);
      bus(1'b0, CTRL_OFFSET, '0);
      `CHK("restart", 32'h93, rdv)
      poll(STATUS_OFFSET, 32'h1, 32'h1);
      `CHK("irq", 1'b1, irqRequest)
      // external input only while enabled with level code 1111
      bus(1'b1, CTRL_OFFSET, 32'h0f);
      @(posedge clk_sys);
      `CHK("ext off", 1'b0, externalTripInput)
      `CHK("detectorOn off", 1'b0, detectorOn)
      poll(CTRL_OFFSET, 32'hff, 32'h0f);
      bus(1'b1, CTRL_OFFSET, 32'h1f);
      @(posedge clk_sys);
      `CHK("ext input", 1'b1, externalTripInput)
      `CHK("level ext", LEVEL_EXT, tripLevelSelect)
      // reset in mid-run restores the off state
      bus(1'b1, CTRL_OFFSET, 32'h9a);
      pulseReset();
      bus(1'b0, CTRL_OFFSET, '0); `CHK("ctrl rerst", 32'h05, rdv)
      bus(1'b0, STATUS_OFFSET, '0); `CHK("status rerst", 32'h0, rdv)
      wrap_up();
   end
endmodule
